// file: verilog/tts_sequencer.sv
// Purpose: Trace qualification, prestore, counting and trigger sequencer
// Assumes: Pattern matches for each qualifier are computed outside
// Notes:   Entries leave through a two-entry buffer; no depth wrap
//
// How it works
// - Up to two latest prestore states precede each stored state.
// - Prestore stays off until a prestore qualifier other than never is set.
// - A state meeting both prestore and store goes out as normal.
// - Prestore entries carry a marker in the count tag field.
// - Time tag counts from the previous normal stored entry only.
// - Count mode none leaves prestore working, tag marker hidden.
// - Defaults to time counting; depth 512 while counting.
// - State count increments on every captured matching state.
// - Counting off extends depth to 1024 entries.
// - Each term checks primary with occurrence count and secondary together.
// - Primary reaching its occurrence count advances to the next term.
// - Secondary before count done returns to term one, count restarted.
// - One global restart condition shared by all terms, target term one.
// - Primary branch out of the last term asserts the trigger.
// - Reset default: one term any, store all, restart never.
// - Any matches every state; default fires on first captured state.
// - Storage qualifier global; branch states are stored while memory has room for them and their prestores.
// - Restart configured never causes no secondary branch.
// - After trigger keep storing until memory full, then stop.
// - Sequencer reset restores default terms, occurrence, restart and store; prestore and count mode keep their values.
// - Occurrence count programmable from 1 to 65535.
// - At most four sequence terms.
// - The trigger state is stored while memory has room for it and its prestores.

`timescale 1ns/1ps

module tts_sequencer #(
  parameter int STATE_W  = tts_pkg::STATE_W,
  parameter int TERM_MAX = tts_pkg::TERM_MAX
) (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          seq_reset,
  input  wire logic                          trace_start,
  input  wire logic                          state_valid,
  input  wire logic [STATE_W-1:0]            state_data,
  input  wire logic [TERM_MAX-1:0]           prim_pat_hit,
  input  wire logic                          restart_pat_hit,
  input  wire logic                          store_pat_hit,
  input  wire logic                          pre_pat_hit,
  input  wire logic                          cnt_pat_hit,
  input  wire logic                          cfg_load,
  input  wire logic [1:0]                    cfg_last_term,
  input  wire logic [2*TERM_MAX-1:0]         cfg_prim_qual,
  input  wire logic [16*TERM_MAX-1:0]        cfg_prim_occ,
  input  wire logic [1:0]                    cfg_restart_qual,
  input  wire logic [1:0]                    cfg_store_qual,
  input  wire logic [1:0]                    cfg_pre_qual,
  input  wire logic [1:0]                    cfg_cnt_mode,
  input  wire logic                          entry_ready,
  output logic                               entry_valid,
  output tts_pkg::tts_entry_t                entry_data,
  output logic                               trigger,
  output logic                               triggered,
  output logic                               running,
  output logic                               trace_done,
  output logic [1:0]                         term_active,
  output logic [tts_pkg::ADDR_W:0]           stored_count
);

  // Configuration registers
  logic [1:0]               last_reg;
  logic [2*TERM_MAX-1:0]    pq_reg;
  logic [16*TERM_MAX-1:0]   occ_reg;
  logic [1:0]               rq_reg;
  logic [1:0]               sq_reg;
  logic [1:0]               preq_reg;
  logic [1:0]               cm_reg;

  // Run state
  logic [1:0]               term_reg;
  logic [15:0]              occ_cnt_reg;
  logic                     run_reg;
  logic                     trig_reg;
  logic                     trig_p_reg;
  logic                     done_reg;
  logic [31:0]              tag_reg;
  logic [tts_pkg::ADDR_W:0] nstore_reg;

  // Prestore holding slots, [0] is the older one
  logic [STATE_W-1:0]       pre_st_reg [2];
  logic [1:0]               pre_v_reg;

  // Two-entry output buffer
  tts_pkg::tts_entry_t      buf_reg [2];
  logic [1:0]               buf_cnt_reg;

  // Pending emission queue: up to two prestores plus the stored state
  tts_pkg::tts_entry_t      q_reg [3];
  logic [1:0]               q_cnt_reg;

  function automatic logic qual(input logic [1:0] q, input logic hit);
    case (q)
      tts_pkg::TTS_Q_NEVER: qual = 1'b0;
      tts_pkg::TTS_Q_ANY:   qual = 1'b1;
      tts_pkg::TTS_Q_PAT:   qual = hit;
      tts_pkg::TTS_Q_NPAT:  qual = ~hit;
      default:              qual = 1'b0;
    endcase
  endfunction

  wire [1:0]  cur_pq    = pq_reg[2*term_reg +: 2];
  wire [15:0] cur_occ   = occ_reg[16*term_reg +: 16];
  wire        cap       = state_valid & run_reg & (q_cnt_reg == 2'h0);
  wire        prim_m    = qual(cur_pq, prim_pat_hit[term_reg]);
  wire        rst_m     = qual(rq_reg, restart_pat_hit);
  wire        store_m   = qual(sq_reg, store_pat_hit);
  wire        pre_on    = preq_reg != tts_pkg::TTS_Q_NEVER;
  wire        pre_m     = pre_on & qual(preq_reg, pre_pat_hit);
  wire        cnt_m     = qual(2'h2, cnt_pat_hit);
  wire        occ_done  = prim_m & (occ_cnt_reg + 16'h0001 >= cur_occ);
  wire        adv       = cap & ~trig_reg & occ_done;
  wire        restart   = cap & ~trig_reg & ~occ_done & rst_m;
  wire        fire      = adv & (term_reg == last_reg);
  wire        branch    = adv | restart;
  wire        do_store  = cap & (store_m | branch);
  wire        do_pre    = cap & pre_m & ~do_store;
  wire [10:0] depth     = (cm_reg == tts_pkg::TTS_CNT_NONE) ?
                          11'(tts_pkg::DEPTH_NOCNT) :
                          11'(tts_pkg::DEPTH_COUNT);
  wire [1:0]  n_pre     = {1'b0, pre_v_reg[0]} + {1'b0, pre_v_reg[1]};
  wire [10:0] need      = nstore_reg + 11'(n_pre) + 11'h001;
  wire        room      = need <= depth;
  wire        full      = nstore_reg >= depth;
  wire        buf_push  = (q_cnt_reg != 2'h0) & (buf_cnt_reg != 2'h2);
  wire        buf_pop   = (buf_cnt_reg != 2'h0) & entry_ready;
  wire [31:0] tag_inc   = tag_reg + 32'h0000_0001;
  wire        cnt_state = cm_reg == tts_pkg::TTS_CNT_STATE;

  function automatic tts_pkg::tts_entry_t mk(input logic [STATE_W-1:0] s,
                                             input logic p,
                                             input logic b,
                                             input logic [31:0] t);
    mk.state    = s;
    mk.prestore = p;
    mk.branch   = b;
    mk.tag      = t;
  endfunction

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_reg <= tts_pkg::RST_TERMS;
      pq_reg   <= {TERM_MAX{2'h1}};
      occ_reg  <= {TERM_MAX{tts_pkg::RST_OCC}};
      rq_reg   <= 2'h0;
      sq_reg   <= 2'h1;
      preq_reg <= 2'h0;
      cm_reg   <= 2'h0;
    end else if (seq_reset) begin
      last_reg <= tts_pkg::RST_TERMS;
      pq_reg   <= {TERM_MAX{2'h1}};
      occ_reg  <= {TERM_MAX{tts_pkg::RST_OCC}};
      rq_reg   <= 2'h0;
      sq_reg   <= 2'h1;
    end else if (cfg_load & ~run_reg) begin
      last_reg <= cfg_last_term;
      pq_reg   <= cfg_prim_qual;
      occ_reg  <= cfg_prim_occ;
      rq_reg   <= cfg_restart_qual;
      sq_reg   <= cfg_store_qual;
      preq_reg <= cfg_pre_qual;
      cm_reg   <= cfg_cnt_mode;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      term_reg    <= 2'h0;
      occ_cnt_reg <= 16'h0000;
      run_reg     <= 1'b0;
      trig_reg    <= 1'b0;
      trig_p_reg  <= 1'b0;
      done_reg    <= 1'b0;
      nstore_reg  <= '0;
    end else begin
      trig_p_reg <= fire;
      if (trace_start) begin
        term_reg    <= 2'h0;
        occ_cnt_reg <= 16'h0000;
        run_reg     <= 1'b1;
        trig_reg    <= 1'b0;
        done_reg    <= 1'b0;
        nstore_reg  <= '0;
      end else begin
        if (adv) begin
          occ_cnt_reg <= 16'h0000;
          if (!fire)
            term_reg <= term_reg + 2'h1;
        end else if (restart) begin
          term_reg    <= 2'h0;
          occ_cnt_reg <= 16'h0000;
        end else if (cap & prim_m & ~trig_reg) begin
          occ_cnt_reg <= occ_cnt_reg + 16'h0001;
        end
        if (fire)
          trig_reg <= 1'b1;
        if (do_store & room)
          nstore_reg <= need;
        // Stop only once triggered; before the trigger a full memory takes no more entries
        if (run_reg & trig_reg & full) begin
          run_reg  <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  // Count tag and prestore capture
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tag_reg       <= 32'h0000_0000;
      pre_v_reg     <= 2'h0;
      pre_st_reg[0] <= '0;
      pre_st_reg[1] <= '0;
    end else if (trace_start) begin
      tag_reg   <= 32'h0000_0000;
      pre_v_reg <= 2'h0;
    end else begin
      if (do_store)
        // Time restarts at one so the tag is the full cycle distance
        tag_reg <= {31'h0, cm_reg == tts_pkg::TTS_CNT_TIME};
      else if (cm_reg == tts_pkg::TTS_CNT_TIME)
        tag_reg <= tag_inc;
      else if (cnt_state & cap & cnt_m)
        tag_reg <= tag_inc;
      if (do_store) begin
        pre_v_reg <= 2'h0;
      end else if (do_pre) begin
        pre_st_reg[0] <= pre_st_reg[1];
        pre_st_reg[1] <= state_data;
        pre_v_reg     <= {1'b1, pre_v_reg[1]};
      end
    end
  end

  wire [31:0] pre_tag = (cm_reg == tts_pkg::TTS_CNT_NONE) ?
                        32'h0000_0000 : tts_pkg::PRESTORE_TAG;
  wire [31:0] st_tag  = (cm_reg == tts_pkg::TTS_CNT_NONE) ? 32'h0000_0000 :
                        (cnt_state & cnt_m) ? tag_inc : tag_reg;

  // Queue holds one stored state with its prestores, drained in order
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_cnt_reg <= 2'h0;
      q_reg[0]  <= '0;
      q_reg[1]  <= '0;
      q_reg[2]  <= '0;
    end else if (do_store & room) begin
      q_reg[0] <= pre_v_reg[0] ? mk(pre_st_reg[0], 1'b1, 1'b0, pre_tag) :
                  pre_v_reg[1] ? mk(pre_st_reg[1], 1'b1, 1'b0, pre_tag) :
                  mk(state_data, 1'b0, branch, st_tag);
      q_reg[1] <= (pre_v_reg == 2'h3) ? mk(pre_st_reg[1], 1'b1, 1'b0, pre_tag)
                  : mk(state_data, 1'b0, branch, st_tag);
      q_reg[2] <= mk(state_data, 1'b0, branch, st_tag);
      q_cnt_reg <= 2'(n_pre) + 2'h1;
    end else if (buf_push) begin
      q_reg[0]  <= q_reg[1];
      q_reg[1]  <= q_reg[2];
      q_cnt_reg <= q_cnt_reg - 2'h1;
    end
  end

  // Capture stalls while the queue drains, so no word is dropped
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_cnt_reg <= 2'h0;
      buf_reg[0]  <= '0;
      buf_reg[1]  <= '0;
    end else begin
      case ({buf_push, buf_pop})
        2'b10: begin
          buf_reg[buf_cnt_reg[0]] <= q_reg[0];
          buf_cnt_reg <= buf_cnt_reg + 2'h1;
        end
        2'b01: begin
          buf_reg[0]  <= buf_reg[1];
          buf_cnt_reg <= buf_cnt_reg - 2'h1;
        end
        2'b11: begin
          if (buf_cnt_reg == 2'h1)
            buf_reg[0] <= q_reg[0];
          else begin
            buf_reg[0] <= buf_reg[1];
            buf_reg[1] <= q_reg[0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign entry_valid  = buf_cnt_reg != 2'h0;
  assign entry_data   = buf_reg[0];
  assign trigger      = trig_p_reg;
  assign triggered    = trig_reg;
  assign running      = run_reg;
  assign trace_done   = done_reg;
  assign term_active  = term_reg;
  assign stored_count = nstore_reg;

endmodule

// file: pkg/tts_pkg.sv
// Purpose: Shared constants and types for the trace trigger sequencer
// Assumes: One captured bus state per ref_clk cycle when state_valid is high
// Notes:   Qualifiers are chosen per use from a small set of sources

package tts_pkg;

  localparam int STATE_W      = 80;
  localparam int COUNT_W      = 32;
  localparam int TERM_MAX     = 4;
  localparam int OCC_W        = 16;
  localparam int DEPTH_COUNT  = 512;
  localparam int DEPTH_NOCNT  = 1024;
  localparam int PRESTORE_MAX = 2;
  localparam int ADDR_W       = 10;

  // Qualifier selection; a pattern match result comes in from outside
  typedef enum logic [1:0] {
    TTS_Q_NEVER = 2'h0,
    TTS_Q_ANY   = 2'h1,
    TTS_Q_PAT   = 2'h2,
    TTS_Q_NPAT  = 2'h3
  } tts_qual_t;

  // Count qualifier mode
  typedef enum logic [1:0] {
    TTS_CNT_TIME  = 2'h0,
    TTS_CNT_STATE = 2'h1,
    TTS_CNT_NONE  = 2'h2
  } tts_cnt_mode_t;

  localparam logic [1:0]  RST_TERMS     = 2'h0;
  localparam logic [15:0] RST_OCC       = 16'h0001;
  localparam logic [COUNT_W-1:0] PRESTORE_TAG = 32'hffff_ffff;

  // One entry as written to trace memory
  typedef struct packed {
    logic [STATE_W-1:0] state;
    logic               prestore;
    logic               branch;
    logic [COUNT_W-1:0] tag;
  } tts_entry_t;

  localparam int ENTRY_W = STATE_W + 2 + COUNT_W;

endpackage

// file: sim/tts_checker.sv
// Purpose: Port assertions for the trace trigger sequencer
// Assumes: One ref_clk domain, sys_rst asynchronous active high
// Notes:   Bound into every tts_sequencer instance
`timescale 1ns/1ps
module tts_checker (
  input wire logic                     ref_clk,
  input wire logic                     sys_rst,
  input wire logic                     trace_start,
  input wire logic                     entry_ready,
  input wire logic                     entry_valid,
  input wire tts_pkg::tts_entry_t      entry_data,
  input wire logic                     trigger,
  input wire logic                     triggered,
  input wire logic                     running,
  input wire logic                     trace_done,
  input wire logic [tts_pkg::ADDR_W:0] stored_count
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_trig_pulse: assert property (trigger |=> !trigger)
    else $error("trigger pulse too long");
  a_trig_flag: assert property (trigger |-> triggered)
    else $error("trigger without triggered");
  a_trig_cause: assert property (trigger |-> $past(running))
    else $error("trigger while not running");
  a_trig_stored: assert property (
    trigger |-> ##[0:6] (entry_valid && entry_data.branch))
    else $error("trigger state not stored");
  // Stalled sink must never lose or alter the head word
  a_entry_hold: assert property (entry_valid && !entry_ready
    |=> entry_valid && $stable(entry_data))
    else $error("entry changed while stalled");
  a_pre_tag: assert property (
    entry_valid && entry_data.prestore
    |-> entry_data.tag == tts_pkg::PRESTORE_TAG || entry_data.tag == 0)
    else $error("prestore marker wrong");
  a_done_stop: assert property (trace_done |-> !running)
    else $error("still running when done");
  a_done_depth: assert property ($rose(trace_done) |-> triggered
    && (stored_count == tts_pkg::DEPTH_COUNT
    || stored_count == tts_pkg::DEPTH_NOCNT))
    else $error("trace stopped at wrong depth");
  a_idle_count: assert property (
    !running && !trace_start |=> $stable(stored_count))
    else $error("stored while idle");
endmodule
bind tts_sequencer tts_checker u_chk (.*);

// file: sim/tts_bus_model.sv
// Purpose: Emulated processor bus, one captured state per request
// Assumes: Pattern matches travel with the state they belong to
// Notes:   Idle bus inverts its data every cycle, so a stale state shows every other cycle
`timescale 1ns/1ps
module tts_bus_model (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        go,
  input  wire logic        stream,
  input  wire logic [79:0] d_in,
  input  wire logic [7:0]  hit_in,
  output logic             state_valid,
  output logic [79:0]      state_data,
  output logic [7:0]       hit
);
  // One state per clock at most
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_valid <= 1'b0;
      state_data  <= '0;
      hit         <= 8'h00;
    end else begin
      state_valid <= go | stream;
      state_data  <= go ? d_in : (stream ? state_data + 1 : ~state_data);
      hit         <= go ? hit_in : 8'h00;
    end
  end
endmodule

// file: sim/tb.sv
// Purpose: Self-checking bench for the trace trigger sequencer
// Assumes: Reset between scenarios, config loads only while idle
// Notes:   Sends are spaced so the entry queue is always free
`timescale 1ns/1ps
module tb;
  logic ref_clk, sys_rst, seq_reset, trace_start, cfg_load, go, stream;
  logic entry_ready, state_valid, entry_valid, trigger, triggered;
  logic running, trace_done, restart_pat_hit, store_pat_hit;
  logic pre_pat_hit, cnt_pat_hit;
  logic [1:0]  cfg_last_term, cfg_restart_qual, cfg_store_qual, cm;
  logic [1:0]  cfg_pre_qual, cfg_cnt_mode, term_active;
  logic [3:0]  prim_pat_hit;
  logic [7:0]  cfg_prim_qual, hit_in, hit;
  logic [63:0] cfg_prim_occ;
  logic [79:0] d_in, state_data;
  logic [10:0] stored_count;
  logic [31:0] tg;
  tts_pkg::tts_entry_t entry_data;
  int          n_mismatch = 0, total_checks = 0, n_trig = 0;

  assign {cnt_pat_hit, pre_pat_hit, store_pat_hit, restart_pat_hit,
    prim_pat_hit} = hit;
  tts_bus_model model (.*);
  tts_sequencer uut (.*);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (trigger === 1'b1) n_trig++;

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rst;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    entry_ready <= 1'b0;
    stream <= 1'b0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic setup(input logic [1:0] lt, input logic [7:0] pq,
      input logic [63:0] oc, input logic [1:0] rq, sq, pr, cn);
    @(posedge ref_clk);
    {cfg_last_term, cfg_prim_qual, cfg_prim_occ} <= {lt, pq, oc};
    {cfg_restart_qual, cfg_store_qual} <= {rq, sq};
    {cfg_pre_qual, cfg_cnt_mode, cfg_load} <= {pr, cn, 1'b1};
    @(posedge ref_clk);
    cfg_load <= 1'b0;
  endtask
  task automatic start;
    @(posedge ref_clk);
    trace_start <= 1'b1;
    @(posedge ref_clk);
    trace_start <= 1'b0;
  endtask
  task automatic send(input logic [79:0] d, input logic [7:0] h);
    @(posedge ref_clk);
    {go, d_in, hit_in} <= {1'b1, d, h};
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic pop(input logic [79:0] s, input logic p, b,
      output logic [31:0] t);
    int i;
    i = 0;
    @(negedge ref_clk);
    while (entry_valid !== 1'b1 && i < 50) begin
      @(negedge ref_clk);
      i++;
    end
    chk({entry_valid, entry_data.state, entry_data.prestore,
      entry_data.branch}, {1'b1, s, p, b});
    t = entry_data.tag;
    @(posedge ref_clk);
    entry_ready <= 1'b1;
    @(posedge ref_clk);
    entry_ready <= 1'b0;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    results();
  end

  initial begin
    {sys_rst, seq_reset, trace_start, cfg_load, go, stream} = '0;
    {entry_ready, cfg_last_term, cfg_prim_qual, cfg_prim_occ} = '0;
    {cfg_restart_qual, cfg_store_qual, cfg_pre_qual, cfg_cnt_mode} = '0;
    {d_in, hit_in} = '0;
    rst();
    // Odd config first, then sequencer reset must bring back defaults
    setup(2'h0, 8'h00, 64'h1, tts_pkg::TTS_Q_PAT, tts_pkg::TTS_Q_PAT,
      tts_pkg::TTS_Q_NEVER, tts_pkg::TTS_CNT_TIME);
    @(posedge ref_clk);
    seq_reset <= 1'b1;
    @(posedge ref_clk);
    seq_reset <= 1'b0;
    start();
    send(80'h4, 8'h00);
    chk(n_trig, 1);
    pop(80'h4, 1'b0, 1'b1, tg);
    // Two terms, occurrence two then one, restart on pattern; then restart never
    rst();
    setup(2'h1, 8'h0a, 64'h1_0002, tts_pkg::TTS_Q_PAT,
      tts_pkg::TTS_Q_NEVER, tts_pkg::TTS_Q_NEVER, tts_pkg::TTS_CNT_TIME);
    entry_ready <= 1'b1;
    start();
    send(80'h1, 8'h01);
    chk(term_active, 2'h0);
    send(80'h2, 8'h10);
    send(80'h3, 8'h01);
    chk(term_active, 2'h0);
    send(80'h4, 8'h01);
    chk(term_active, 2'h1);
    send(80'h5, 8'h11);
    chk(term_active, 2'h0);
    send(80'h6, 8'h01);
    send(80'h7, 8'h01);
    chk(n_trig, 1);
    send(80'h8, 8'h12);
    chk(n_trig, 2);
    rst();
    setup(2'h1, 8'h09, 64'h1_0001, tts_pkg::TTS_Q_NEVER,
      tts_pkg::TTS_Q_ANY, tts_pkg::TTS_Q_NEVER, tts_pkg::TTS_CNT_TIME);
    entry_ready <= 1'b1;
    start();
    send(80'h1, 8'h10);
    send(80'h2, 8'h10);
    chk(term_active, 2'h1);
    // Prestore with sink stalled, time then no counting; then state count tag
    for (int m = 0; m < 2; m++) begin
      cm = m ? tts_pkg::TTS_CNT_NONE : tts_pkg::TTS_CNT_TIME;
      rst();
      setup(2'h0, 8'h01, 64'h1, tts_pkg::TTS_Q_NEVER, tts_pkg::TTS_Q_PAT,
        tts_pkg::TTS_Q_PAT, cm);
      start();
      for (int k = 5; k < 10; k++)
        send(80'(k), k == 9 ? 8'h20 : (k == 5 ? 8'h00 : 8'h40));
      pop(80'h5, 1'b0, 1'b1, tg);
      pop(80'h7, 1'b1, 1'b0, tg);
      chk(tg, m ? 32'h0 : tts_pkg::PRESTORE_TAG);
      pop(80'h8, 1'b1, 1'b0, tg);
      pop(80'h9, 1'b0, 1'b0, tg);
      chk(tg, m ? 32'h0 : 32'h14);
      send(80'ha, 8'h60);
      pop(80'ha, 1'b0, 1'b0, tg);
    end
    rst();
    setup(2'h0, 8'h01, 64'h1, tts_pkg::TTS_Q_NEVER, tts_pkg::TTS_Q_NPAT,
      tts_pkg::TTS_Q_NEVER, tts_pkg::TTS_CNT_STATE);
    start();
    send(80'h1, 8'h20);
    for (int k = 0; k < 3; k++) send(80'h2, 8'he0);
    send(80'h3, 8'h00);
    pop(80'h1, 1'b0, 1'b1, tg);
    pop(80'h3, 1'b0, 1'b0, tg);
    chk(tg, 32'h3);
    // Fill trace memory, default time counting then none
    for (int m = 0; m < 2; m++) begin
      rst();
      if (m) setup(2'h0, 8'h01, 64'h1, tts_pkg::TTS_Q_NEVER,
        tts_pkg::TTS_Q_ANY, tts_pkg::TTS_Q_NEVER, tts_pkg::TTS_CNT_NONE);
      entry_ready <= 1'b1;
      start();
      stream <= 1'b1;
      for (int i = 0; i < 5000 && trace_done !== 1'b1; i++)
        @(negedge ref_clk);
      chk(stored_count, m ? 1024 : 512);
      chk(running, 1'b0);
      chk(trace_done, 1'b1);
      chk(triggered, 1'b1);
    end
    results();
  end
endmodule
